// File: dv/pin_routing_lock_tb_top.sv
// self-checking bench for the pin routing lock
`timescale 1ns/10ps
module pin_routing_lock_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic dev_rst_i = 1'b0;
  logic sleep_i = 1'b0;
  logic fuse = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic bset = 1'b0;
  logic bclr = 1'b0;
  logic [2:0] bidx = 3'h0;
  logic rd = 1'b0;
  logic swr = 1'b0;
  logic [2:0] sa = 3'h0;
  logic [5:0] sd = 6'h00;
  logic [47:0] sel_o;
  logic locked_o;
  logic spent_o;
  int mismatches = 0;
  int comparisons = 0;
  int ce_mode = 0;
  int seed = 32'h004898e9;
  int m_sel[8] = '{default: 0};
  int m_lk = 0;
  int m_sp = 0;
  int m_cl = 0;
  int m_key = 0;
  int m_fw = 0;
  int ks[8] = '{1, 1, 1, 2, 3, 5, 4, 6};
  int k;
  int a;

  pin_routing_lock pin_routing_lock_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .dev_rst_i(dev_rst_i),
    .sleep_i(sleep_i), .one_way_lock_fuse_i(fuse), .lock_wr_i(wr), .lock_wdata_i(wd),
    .single_bit_set_op_i(bset), .single_bit_clear_op_i(bclr), .lock_bit_i(bidx),
    .lock_rd_i(rd), .sel_wr_i(swr), .sel_addr_i(sa), .sel_wdata_i(sd), .sel_o(sel_o),
    .routing_locked_bit_o(locked_o), .one_way_spent_o(spent_o)
  );

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // kinds: 1 write, 2 set, 3 clear, 4 read, 5 selection, 6 dev reset, 7 por, 8 set+clear
  task automatic op(int k, int a = 0, int b = 0);
    logic [47:0] es;
    logic ok;
    logic cen;
    @(posedge clk_sys_i);
    sleep_i <= 1'($random(seed));
    cen = (ce_mode == 0) || ($random(seed) % 4 != 0);
    ce <= cen;
    rst_i <= (k == 7);
    dev_rst_i <= (k == 6);
    wr <= (k == 1);
    wd <= 8'(a);
    bset <= (k == 2) || (k == 8);
    bclr <= (k == 3) || (k == 8);
    bidx <= 3'(a);
    rd <= (k == 4);
    swr <= (k == 5);
    sa <= 3'(a);
    sd <= 6'(b);
    ok = (m_key == 2) && (a == int'(routing_lock_pkg::LOCK_BIT_POS));
    // a frozen edge drops the access; resets still act
    case ((cen || k == 6 || k == 7) ? k : 0)
      1: m_key = (a == routing_lock_pkg::KEY_FIRST && m_key == 0) ? 1 :
                 (a == routing_lock_pkg::KEY_SECOND && m_key == 1) ? 2 : 0;
      2, 3, 8: begin
        if (ok && k == 2 && !(m_fw && m_sp)) begin
          m_lk = 1;
          m_sp = 1;
        end
        if (ok && k == 3 && !(m_fw && (m_sp || m_cl))) begin
          m_lk = 0;
          m_cl = 1;
        end
        m_key = 0;
      end
      4: m_key = 0;
      5: if (!m_lk) m_sel[a] = b & 63;
      6, 7: begin
        m_lk = 0;
        m_sp = 0;
        m_cl = 0;
        m_key = 0;
        if (k == 7) m_sel = '{default: 0};
        if (k == 7) m_fw = fuse;
      end
      default: ;
    endcase
    @(posedge clk_sys_i);
    {rst_i, dev_rst_i, wr, bset, bclr, rd, swr} <= 7'h00;
    ce <= 1'b1;
    #1;
    for (int i = 0; i < 8; i++) es[i*6+:6] = 6'(m_sel[i]);
    check("sel_o", sel_o, es);
    check("locked", 48'(locked_o), 48'(m_lk));
    check("spent", 48'(spent_o), 48'(m_sp));
  endtask

  // key pair then bit op with nothing between, as masked software would do
  task automatic keys(int k, int a);
    op(1, routing_lock_pkg::KEY_FIRST);
    op(1, routing_lock_pkg::KEY_SECOND);
    op(k, a);
  endtask

  task automatic por(logic f);
    fuse <= f;
    op(7);
    op(0);
    op(0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // long enough for every op at two cycles each, with margin
    #(25 * 12000);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    op(0);
    op(0);
    for (int i = 0; i < 8; i++) op(5, i, $random(seed));
    keys(2, 0);
    op(5, 3, 9);
    op(1, 85);
    op(1, 170);
    op(1, 0);
    op(3, 0);
    op(1, 85);
    op(4);
    op(1, 170);
    op(3, 0);
    op(1, 85);
    keys(3, 0);
    keys(3, 1);
    keys(8, 0);
    keys(3, 0);
    op(5, 3, 9);
    keys(2, 0);
    op(6);
    por(1'b1);
    keys(3, 0);
    keys(2, 0);
    keys(3, 0);
    op(6);
    keys(3, 0);
    keys(2, 0);
    keys(3, 0);
    op(6);
    keys(2, 0);
    keys(3, 0);
    // random traffic in both fuse modes, sleep toggling throughout
    ce_mode = 1;
    for (int f = 0; f < 2; f++) begin
      por(1'(f));
      repeat (1500) begin
        k = ks[$unsigned($random(seed)) % 8];
        a = $unsigned($random(seed)) % 8;
        if (k == 1) a = (a < 3) ? 85 : (a < 6) ? 170 : a;
        if (k == 2 || k == 3) a = (a < 6) ? 0 : a;
        op(k, a, $random(seed));
      end
    end
    end_of_test();
  end
endmodule

// File: verilog/pin_routing_lock.sv
// pin routing lock: key sequence, lock bit, one-way lock and reset handling
`timescale 1ns/10ps

// Operation
// - while locked, writes to every routing selection are ignored
// - lock bit changes only on the access right after writes 55h then AAh
// - only a single-bit set or clear alters the lock bit, never whole writes
// - clearing the lock re-enables selection writes, setting it disables them
// - with the one-way fuse, lock may be cleared once and set once per reset
// - in one-way mode, once set the lock stays set until device reset or power-on reset
// - sleep entry and exit leave all selections unchanged
// - power-on reset returns every selection to its default
// - any other reset keeps the current selections
// - a device reset clears the one-way history
module pin_routing_lock #(
  parameter int NUM_SEL = routing_lock_pkg::NUM_SEL_DEF,
  parameter int SEL_W = routing_lock_pkg::SEL_W_DEF,
  parameter int AW = (NUM_SEL > 1) ? $clog2(NUM_SEL) : 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic dev_rst_i,
  input wire logic sleep_i,
  input wire logic one_way_lock_fuse_i,
  input wire logic lock_wr_i,
  input wire logic [7:0] lock_wdata_i,
  input wire logic single_bit_set_op_i,
  input wire logic single_bit_clear_op_i,
  input wire logic [2:0] lock_bit_i,
  input wire logic lock_rd_i,
  input wire logic sel_wr_i,
  input wire logic [AW-1:0] sel_addr_i,
  input wire logic [SEL_W-1:0] sel_wdata_i,
  output logic [NUM_SEL*SEL_W-1:0] sel_o,
  output logic routing_locked_bit_o,
  output logic one_way_spent_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GOT_FIRST,
    ST_ARMED
  } key_state_e;

  function automatic logic is_lock_bit(input logic [2:0] pos);
    return pos == routing_lock_pkg::LOCK_BIT_POS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fuse synchroniser: the fuse level is not tied to this clock

  logic fuse_meta_q;
  logic fuse_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fuse_meta_q <= 1'b0;
      fuse_q <= 1'b0;
    end else if (ce_i) begin
      fuse_meta_q <= one_way_lock_fuse_i;
      fuse_q <= fuse_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key sequence

  key_state_e st_q;
  key_state_e st_d;
  logic any_acc;

  assign any_acc = lock_wr_i | single_bit_set_op_i | single_bit_clear_op_i | lock_rd_i;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (lock_wr_i && lock_wdata_i == routing_lock_pkg::KEY_FIRST) begin
          st_d = ST_GOT_FIRST;
        end
      end
      ST_GOT_FIRST: begin
        if (lock_wr_i && lock_wdata_i == routing_lock_pkg::KEY_SECOND) begin
          st_d = ST_ARMED;
        end else if (any_acc) begin
          st_d = ST_IDLE;
        end
      end
      ST_ARMED: begin
        // armed for exactly one access, whatever it is
        if (any_acc) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || dev_rst_i) begin
      st_q <= ST_IDLE;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock bit and one-way history

  logic locked_q;
  logic set_once_q;
  logic cleared_once_q;
  logic set_req;
  logic clr_req;
  logic set_ok;
  logic clr_ok;

  // a whole-register write never reaches these requests; both at once is refused
  assign set_req = st_q == ST_ARMED && single_bit_set_op_i && !single_bit_clear_op_i
    && !lock_wr_i && is_lock_bit(lock_bit_i);
  assign clr_req = st_q == ST_ARMED && single_bit_clear_op_i && !single_bit_set_op_i
    && !lock_wr_i && is_lock_bit(lock_bit_i);
  assign set_ok = set_req && !(fuse_q && set_once_q);
  assign clr_ok = clr_req && !(fuse_q && (set_once_q || cleared_once_q));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || dev_rst_i) begin
      locked_q <= routing_lock_pkg::LOCK_RST;
    end else if (ce_i) begin
      if (set_ok) begin
        locked_q <= 1'b1;
      end else if (clr_ok) begin
        locked_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || dev_rst_i) begin
      set_once_q <= 1'b0;
      cleared_once_q <= 1'b0;
    end else if (ce_i) begin
      if (set_ok) begin
        set_once_q <= 1'b1;
      end
      if (clr_ok) begin
        cleared_once_q <= 1'b1;
      end
    end
  end

  assign routing_locked_bit_o = locked_q;
  assign one_way_spent_o = set_once_q;

  ////////////////////////////////////////////////////////////////////////////
  // selection bank; sleep_i is deliberately not wired into it

  sel_bank_if #(.NUM_SEL(NUM_SEL), .SEL_W(SEL_W), .AW(AW)) sel_bus ();

  assign sel_bus.wr_en = sel_wr_i && !locked_q;
  assign sel_bus.addr = sel_addr_i;
  assign sel_bus.wdata = sel_wdata_i;
  assign sel_o = sel_bus.sel_flat;

  routing_sel_bank #(.NUM_SEL(NUM_SEL), .SEL_W(SEL_W)) u_bank (
    .clk_sys_i(clk_sys_i),
    .por_i(rst_i),
    .ce_i(ce_i),
    .bus(sel_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_armed_bit_op(logic op);
    st_q == ST_ARMED && ce_i && !dev_rst_i && op && is_lock_bit(lock_bit_i)
      && !lock_wr_i;
  endsequence

  sequence s_key_pair;
    (st_q == ST_IDLE && ce_i && !dev_rst_i && lock_wr_i
      && lock_wdata_i == routing_lock_pkg::KEY_FIRST)
    ##1 (st_q == ST_GOT_FIRST);
  endsequence

  a_locked_sel_hold: assert property (
    locked_q && sel_wr_i |=> $stable(sel_o))
    else $error("selection changed while locked");

  a_key_arms: assert property (
    s_key_pair ##0 (ce_i && !dev_rst_i && lock_wr_i
      && lock_wdata_i == routing_lock_pkg::KEY_SECOND) |=> st_q == ST_ARMED)
    else $error("key pair did not arm");

  a_unarmed_no_change: assert property (
    st_q != ST_ARMED && !dev_rst_i |=> $stable(locked_q))
    else $error("lock changed without key pair");

  a_whole_wr_no_lock: assert property (
    lock_wr_i && !dev_rst_i |=> $stable(locked_q))
    else $error("whole write altered lock");

  a_unlock_opens: assert property (
    s_armed_bit_op(single_bit_clear_op_i && !single_bit_set_op_i) ##0 !fuse_q
      |=> !locked_q)
    else $error("unlock did not clear the lock");

  // an open write must land in the addressed field, not just leave others alone
  a_open_sel_write: assert property (
    !locked_q && sel_wr_i && ce_i
      |=> sel_o[$past(sel_addr_i) * SEL_W +: SEL_W] == $past(sel_wdata_i))
    else $error("open selection write did not land");

  a_oneway_clear_once: assert property (
    (fuse_q && cleared_once_q && !locked_q && !dev_rst_i)
      and s_armed_bit_op(single_bit_clear_op_i) |=> cleared_once_q && !locked_q)
    else $error("one-way history lost");

  a_oneway_stays_set: assert property (
    fuse_q && set_once_q && locked_q && !dev_rst_i |=> locked_q)
    else $error("one-way lock was cleared");

  a_sleep_sel_hold: assert property (
    $changed(sleep_i) && !sel_wr_i |-> ##1 $stable(sel_o))
    else $error("sleep altered selections");

  a_por_default: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    rst_i |=> sel_o == '0)
    else $error("selection not at default after power-on reset");

  a_devrst_keeps_sel: assert property (
    dev_rst_i && !sel_wr_i |=> $stable(sel_o))
    else $error("device reset altered selections");

  a_devrst_history: assert property (
    dev_rst_i |=> !set_once_q && !cleared_once_q && !locked_q && st_q == ST_IDLE)
    else $error("device reset kept one-way history");

  a_abort_partial: assert property (
    st_q == ST_GOT_FIRST && ce_i && (lock_rd_i || single_bit_set_op_i
      || single_bit_clear_op_i) |=> st_q == ST_IDLE)
    else $error("partial key sequence not aborted");

endmodule

// File: verilog/routing_lock_pkg.sv
// constants shared by the pin routing lock logic
package routing_lock_pkg;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [2:0] LOCK_BIT_POS = 3'h0;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam int NUM_SEL_DEF = 8;
  localparam int SEL_W_DEF = 6;
endpackage

// File: verilog/routing_sel_bank.sv
// storage for the peripheral pin routing selections
`timescale 1ns/10ps
module routing_sel_bank #(
  parameter int NUM_SEL = routing_lock_pkg::NUM_SEL_DEF,
  parameter int SEL_W = routing_lock_pkg::SEL_W_DEF
) (
  input wire logic clk_sys_i,
  input wire logic por_i,
  input wire logic ce_i,
  sel_bank_if.bank bus
);
  logic [SEL_W-1:0] sel_q [NUM_SEL];

  // only power-on reset touches the selections; other resets and sleep leave them
  always_ff @(posedge clk_sys_i) begin
    if (por_i) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_q[i] <= routing_lock_pkg::SEL_RST[SEL_W-1:0];
      end
    end else if (ce_i && bus.wr_en) begin
      sel_q[bus.addr] <= bus.wdata;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SEL; i++) begin
      bus.sel_flat[i*SEL_W +: SEL_W] = sel_q[i];
    end
  end
endmodule

// File: verilog/sel_bank_if.sv
// carrier between the lock logic and the routing selection bank
`timescale 1ns/10ps
interface sel_bank_if #(
  parameter int NUM_SEL = routing_lock_pkg::NUM_SEL_DEF,
  parameter int SEL_W = routing_lock_pkg::SEL_W_DEF,
  parameter int AW = (NUM_SEL > 1) ? $clog2(NUM_SEL) : 1
);
  logic wr_en;
  logic [AW-1:0] addr;
  logic [SEL_W-1:0] wdata;
  logic [NUM_SEL*SEL_W-1:0] sel_flat;

  modport ctrl (
    output wr_en,
    output addr,
    output wdata,
    input sel_flat
  );
  modport bank (
    input wr_en,
    input addr,
    input wdata,
    output sel_flat
  );
endinterface
